// file: sci_civ_meas.v
// measures pixel clock against the reference clock and forms the calculated increment
`timescale 1ns/100ps
`default_nettype none
`include "sci_map.vh"

module sci_civ_meas #(
  parameter [`SCI_WIN_W-1:0] PIX_WINDOW = `SCI_PIX_WINDOW
) (
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    pix_clk_pin,
  input  wire                    ref_clk_pin,
  input  wire [1:0]              hyst_sel,
  output reg  [`SCI_CALC_W-1:0]  calc_q,
  output reg                     calc_valid_q
);

  reg  [2:0]               pix_sync_q;
  reg  [2:0]               ref_sync_q;
  reg  [1:0]               fill_q;
  reg  [`SCI_WIN_W-1:0]    pix_cnt_q;
  reg  [`SCI_CALC_W-1:0]   ref_cnt_q;
  reg  [`SCI_CALC_W-1:0]   thresh;
  reg  [`SCI_CALC_W-1:0]   diff;
  wire                     pix_rise;
  wire                     ref_rise;
  wire                     win_end;

  ////////////////////////////////////////////////////////////////////////////////
  // both clocks are foreign to pclk: two flops, then a third for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_sync_q <= 3'h0;
      ref_sync_q <= 3'h0;
      fill_q     <= 2'h0;
    end else begin
      pix_sync_q <= {pix_sync_q[1:0], pix_clk_pin};
      ref_sync_q <= {ref_sync_q[1:0], ref_clk_pin};
      if (fill_q != `SCI_SYNC_FILL) begin
        fill_q <= fill_q + 1'b1;
      end
    end
  end

  // a pin already high at reset release would look like a rise against the cleared flops
  assign pix_rise = (fill_q == `SCI_SYNC_FILL) & pix_sync_q[1] & ~pix_sync_q[2];
  assign ref_rise = (fill_q == `SCI_SYNC_FILL) & ref_sync_q[1] & ~ref_sync_q[2];
  assign win_end  = pix_rise && (pix_cnt_q == PIX_WINDOW - 1'b1);

  always @* begin
    case (hyst_sel)
      2'h0:    thresh = `SCI_HYST_T0;
      2'h1:    thresh = `SCI_HYST_T1;
      2'h2:    thresh = `SCI_HYST_T2;
      default: thresh = `SCI_HYST_T3;
    endcase
    diff = (ref_cnt_q > calc_q) ? (ref_cnt_q - calc_q) : (calc_q - ref_cnt_q);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference edges counted over a fixed number of pixel edges: count rises as pixel rate falls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_cnt_q    <= {`SCI_WIN_W{1'b0}};
      ref_cnt_q    <= {`SCI_CALC_W{1'b0}};
      calc_q       <= {`SCI_CALC_W{1'b0}};
      calc_valid_q <= 1'b0;
    end else begin
      if (win_end) begin
        pix_cnt_q <= {`SCI_WIN_W{1'b0}};
        ref_cnt_q <= {{(`SCI_CALC_W-1){1'b0}}, ref_rise};
        // small wander below the threshold leaves the value alone
        if (!calc_valid_q || diff > thresh) begin
          calc_q <= ref_cnt_q;
        end
        calc_valid_q <= 1'b1;
      end else begin
        if (pix_rise) begin
          pix_cnt_q <= pix_cnt_q + 1'b1;
        end
        if (ref_rise) begin
          ref_cnt_q <= ref_cnt_q + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: sci_map.vh
// register map, field layout and reset values of the subcarrier increment register bank
`ifndef SCI_MAP_VH
`define SCI_MAP_VH

// register indices; byte address is four times the index
`define SCI_IDX_INC_FIRST   6'h18
`define SCI_IDX_INC_LAST    6'h1F
`define SCI_IDX_CTRL        6'h21
`define SCI_IDX_CALC_HIGH   6'h22
`define SCI_IDX_CALC_MID    6'h23
`define SCI_IDX_CALC_LOW    6'h24
`define SCI_IDX_VERSION     6'h25
`define SCI_IDX_POINTER     6'h3F

// byte address layout on the bus
`define SCI_ADDR_W          8
`define SCI_ADDR_IDX_HI     7
`define SCI_ADDR_IDX_LO     2

// control register fields
`define SCI_CTRL_AUTO_BIT   0
`define SCI_CTRL_HYST_HI    2
`define SCI_CTRL_HYST_LO    1
`define SCI_CTRL_CALC_HI    4
`define SCI_CTRL_CALC_LO    3

// reset values
`define SCI_RST_AUTO        1'b1
`define SCI_RST_HYST        2'h0
`define SCI_RST_POINTER     6'h00
`define SCI_RST_NIBBLE      4'h0

// widths
`define SCI_CALC_W          26
`define SCI_WORD_W          32
`define SCI_LOW_PAD_W       6
`define SCI_WIN_W           25
`define SCI_NIB_W           4
`define SCI_NIB_CNT         8

// calculated increment slices as they appear in the read registers
`define SCI_CALC_TOP_HI     25
`define SCI_CALC_TOP_LO     24
`define SCI_CALC_HIGH_HI    23
`define SCI_CALC_HIGH_LO    16
`define SCI_CALC_MID_HI     15
`define SCI_CALC_MID_LO     8
`define SCI_CALC_LOW_HI     7
`define SCI_CALC_LOW_LO     0

// pclk edges after reset before the edge-detect flop holds a real pin sample
`define SCI_SYNC_FILL       2'h3

// measurement window in pixel clock edges; makes the reference count equal the increment
`define SCI_PIX_WINDOW      25'h1000000

// hysteresis thresholds in counts, by control setting
`define SCI_HYST_T0         26'h0000000
`define SCI_HYST_T1         26'h0000001
`define SCI_HYST_T2         26'h0000002
`define SCI_HYST_T3         26'h0000004

// version identifier; value is arbitrary
`define SCI_VERSION_ID      8'h5A

`endif

// file: sci_regs.v
// subcarrier increment register bank with apb slave and calculated-increment selection
// Operation
// - auto select feeds calculated value to subcarrier
// - calculated value is 26 bits, upper increment bits
// - calculated value from pixel versus reference clock
// - calculated bits readable at 21h through 24h
// - two-bit field sets calculation hysteresis
// - read-only fixed 8-bit version identifier
// - 6-bit pointer holds currently accessed register index
// - 32-bit word in low nibbles 18h-1Fh
`timescale 1ns/100ps
`default_nettype none
`include "sci_map.vh"

module sci_regs #(
  parameter [`SCI_WIN_W-1:0] PIX_WINDOW = `SCI_PIX_WINDOW
) (
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`SCI_ADDR_W-1:0]  paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr,
  input  wire                    pix_clk_pin,
  input  wire                    ref_clk_pin,
  output reg  [`SCI_WORD_W-1:0]  subcarrier_increment_q,
  output reg                     auto_increment_select_q
);

  reg  [3:0]               inc_nib_q [0:7];
  reg  [1:0]               increment_hysteresis_ctrl_q;
  reg  [5:0]               register_pointer_q;
  wire [`SCI_WORD_W-1:0]   subcarrier_increment_word;
  reg  [`SCI_WORD_W-1:0]   inc_d;
  reg  [31:0]              rdata_d;
  reg                      err_d;
  wire [`SCI_CALC_W-1:0]   calculated_increment;
  wire [5:0]               idx;
  wire                     setup;
  wire                     done;
  integer                  k;
  genvar                   g;

  assign idx   = paddr[`SCI_ADDR_IDX_HI:`SCI_ADDR_IDX_LO];
  assign setup = psel && !penable;
  assign done  = psel && penable && pready;

  // true when index falls in the nibble-wide increment word registers
  function is_inc;
    input [5:0] i;
    begin
      is_inc = (i >= `SCI_IDX_INC_FIRST) && (i <= `SCI_IDX_INC_LAST);
    end
  endfunction

  // true for any mapped register
  function is_mapped;
    input [5:0] i;
    begin
      is_mapped = is_inc(i) || (i >= `SCI_IDX_CTRL && i <= `SCI_IDX_VERSION) || (i == `SCI_IDX_POINTER);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  sci_civ_meas #(
    .PIX_WINDOW (PIX_WINDOW)
  ) u_meas (
    .pclk         (pclk),
    .presetn      (presetn),
    .pix_clk_pin  (pix_clk_pin),
    .ref_clk_pin  (ref_clk_pin),
    .hyst_sel     (increment_hysteresis_ctrl_q),
    .calc_q       (calculated_increment),
    .calc_valid_q ()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // most significant nibble sits at the lowest index
  generate
    for (g = 0; g < `SCI_NIB_CNT; g = g + 1) begin : g_pack
      assign subcarrier_increment_word[(`SCI_WORD_W-1-`SCI_NIB_W*g) -: `SCI_NIB_W] = inc_nib_q[g];
    end
  endgenerate

  always @* begin
    // auto mode replaces only the upper bits; low bits stay as programmed
    if (auto_increment_select_q) begin
      inc_d = {calculated_increment, subcarrier_increment_word[`SCI_LOW_PAD_W-1:0]};
    end else begin
      inc_d = subcarrier_increment_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data is prepared in the setup phase so prdata leaves a flop
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (is_inc(idx)) begin
      rdata_d[3:0] = inc_nib_q[idx[2:0]];
    end else if (idx == `SCI_IDX_CTRL) begin
      rdata_d[`SCI_CTRL_AUTO_BIT]                 = auto_increment_select_q;
      rdata_d[`SCI_CTRL_HYST_HI:`SCI_CTRL_HYST_LO] = increment_hysteresis_ctrl_q;
      rdata_d[`SCI_CTRL_CALC_HI:`SCI_CTRL_CALC_LO] = calculated_increment[`SCI_CALC_TOP_HI:`SCI_CALC_TOP_LO];
    end else if (idx == `SCI_IDX_CALC_HIGH) begin
      rdata_d[7:0] = calculated_increment[`SCI_CALC_HIGH_HI:`SCI_CALC_HIGH_LO];
    end else if (idx == `SCI_IDX_CALC_MID) begin
      rdata_d[7:0] = calculated_increment[`SCI_CALC_MID_HI:`SCI_CALC_MID_LO];
    end else if (idx == `SCI_IDX_CALC_LOW) begin
      rdata_d[7:0] = calculated_increment[`SCI_CALC_LOW_HI:`SCI_CALC_LOW_LO];
    end else if (idx == `SCI_IDX_VERSION) begin
      rdata_d[7:0] = `SCI_VERSION_ID;
    end else if (idx == `SCI_IDX_POINTER) begin
      rdata_d[5:0] = register_pointer_q;
    end else begin
      err_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // no wait state on any transfer: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
      pready  <= 1'b1;
      pslverr <= err_d;
    end else begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // writes land at the completing edge; read-only bits ignore write data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < `SCI_NIB_CNT; k = k + 1) begin
        inc_nib_q[k] <= `SCI_RST_NIBBLE;
      end
      auto_increment_select_q     <= `SCI_RST_AUTO;
      increment_hysteresis_ctrl_q <= `SCI_RST_HYST;
      register_pointer_q          <= `SCI_RST_POINTER;
      subcarrier_increment_q      <= {`SCI_WORD_W{1'b0}};
    end else begin
      subcarrier_increment_q <= inc_d;
      if (done && is_mapped(idx)) begin
        // pointer tracks the register touched; a write to the pointer itself sets it
        if (pwrite && idx == `SCI_IDX_POINTER) begin
          register_pointer_q <= pwdata[5:0];
        end else begin
          register_pointer_q <= idx;
        end
        if (pwrite && is_inc(idx)) begin
          inc_nib_q[idx[2:0]] <= pwdata[3:0];
        end
        if (pwrite && idx == `SCI_IDX_CTRL) begin
          auto_increment_select_q     <= pwdata[`SCI_CTRL_AUTO_BIT];
          increment_hysteresis_ctrl_q <= pwdata[`SCI_CTRL_HYST_HI:`SCI_CTRL_HYST_LO];
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: sci_regs_asserts.sv
// port assertions for the subcarrier increment register bank
`timescale 1ns/100ps
`default_nettype none
`include "sci_map.vh"
module sci_regs_asserts #(
  parameter [`SCI_WIN_W-1:0] PIX_WINDOW = `SCI_PIX_WINDOW
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pix_clk_pin,
  input wire logic        ref_clk_pin,
  input wire logic [31:0] subcarrier_increment_q,
  input wire logic        auto_increment_select_q
);
  wire [5:0] idx = paddr[7:2];
  wire       rd  = !pwrite;
  wire       map = (idx >= 6'h18 && idx <= 6'h1F) || (idx >= 6'h21 && idx <= 6'h25) || idx == 6'h3F;
  ////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_rdy; s_setup |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_once; s_done |=> !pready; endproperty
  a_once: assert property (p_once) else $error("ready held");
  property p_unmap; s_setup ##0 !map |=> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("no slave error");
  property p_vid; s_done ##0 (rd && idx == 6'h25) |-> prdata == {24'h0, `SCI_VERSION_ID}; endproperty
  a_vid: assert property (p_vid) else $error("version wrong");
  property p_auto; s_done ##0 (pwrite && idx == 6'h21) |=> auto_increment_select_q == $past(pwdata[0]); endproperty
  a_auto: assert property (p_auto) else $error("select not taken");
  property p_nib; s_done ##0 (pwrite && idx == 6'h1F) |=> ##1 subcarrier_increment_q[3:0] == $past(pwdata[3:0], 2);
  endproperty
  a_nib: assert property (p_nib) else $error("nibble not used");
  property p_ctl; s_done ##0 (rd && idx == 6'h21) |-> prdata[0] == auto_increment_select_q && prdata[31:5] == 27'h0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control read");
  property p_calc;
    s_done ##0 (rd && idx == 6'h24 && auto_increment_select_q && $stable(subcarrier_increment_q))
      |-> prdata[7:0] == subcarrier_increment_q[13:6];
  endproperty
  a_calc: assert property (p_calc) else $error("calc not used");
endmodule
bind sci_regs sci_regs_asserts #(.PIX_WINDOW(PIX_WINDOW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pix_clk_pin(pix_clk_pin), .ref_clk_pin(ref_clk_pin),
  .subcarrier_increment_q(subcarrier_increment_q), .auto_increment_select_q(auto_increment_select_q));
`default_nettype wire

// file: sci_regs_bench.sv
// self-checking bench for the subcarrier increment register bank
`timescale 1ns/100ps
`default_nettype none
`include "sci_map.vh"
module sci_regs_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pix = 0, refc = 0, pready, pslverr, err, auto;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, sub;
  int          num_errors = 0, checked = 0;
  int          pix_div = 0, ref_div = 0, ref_half = 10;
  logic [5:0]  r_i [12] = '{6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h21, 6'h22, 6'h25, 6'h3F};
  logic [31:0] r_w [12] = '{32'hFFFFFFF1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h7, 32'h8, 32'hE6, 32'hFF, 32'hFF,
                            32'hD5};
  logic [31:0] r_e [12] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h7, 32'h8, 32'h6, 32'h0,
                            {24'h0, `SCI_VERSION_ID}, 32'h15};
  // short window keeps a measurement to 16 pixel edges
  sci_regs #(.PIX_WINDOW(25'h10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_clk_pin(pix), .ref_clk_pin(refc), .subcarrier_increment_q(sub), .auto_increment_select_q(auto));
  initial forever #4 pclk = ~pclk;
  // pixel period 10 cycles; reference period 2*ref_half cycles: a 16-edge window holds 8 or 10 rises
  always @(posedge pclk) begin
    pix_div <= (pix_div == 4) ? 0 : pix_div + 1;
    ref_div <= (ref_div >= ref_half - 1) ? 0 : ref_div + 1;
    if (pix_div == 4) pix <= ~pix;
    if (ref_div >= ref_half - 1) refc <= ~refc;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic results;
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 12; k++) begin
      apb(1'b1, r_i[k], r_w[k]);
      apb(1'b0, r_i[k], 32'h0);
      chk(rd, r_e[k]);
    end
    chk(sub, 32'h12345678);
    apb(1'b1, 6'h21, 32'h1);
    // the first window after reset is partial; later ones count exactly
    repeat (400) @(posedge pclk);
    apb(1'b0, 6'h24, 32'h0);
    chk(rd, 32'h8);
    chk(sub, 32'h238);
    // faster reference: a step of 2 counts must not exceed threshold 2 and must pass threshold 1
    apb(1'b1, 6'h21, 32'h5);
    ref_half <= 8;
    repeat (400) @(posedge pclk);
    apb(1'b0, 6'h24, 32'h0);
    chk(rd, 32'h8);
    chk(sub, 32'h238);
    apb(1'b1, 6'h21, 32'h3);
    repeat (400) @(posedge pclk);
    apb(1'b0, 6'h24, 32'h0);
    chk(rd, 32'hA);
    chk(sub, 32'h2B8);
    apb(1'b0, 6'h30, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 6'h20, 32'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 6'h3F, 32'h0);
    chk(rd, 32'h24);
    presetn <= 1'b0;
    @(posedge pclk);
    chk(sub, 32'h0);
    chk({31'h0, auto}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 6'h21, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 6'h1F, 32'h0);
    chk(rd, 32'h0);
    results;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    results;
  end
endmodule
`default_nettype wire
